// ===== hdl/pic_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl #(
    parameter int NUM_EXT = pic_pkg::NUM_EXT,
    parameter int NUM_HSC = pic_pkg::NUM_HSC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // command port from the core
    input wire logic clear_pending_command,
    input wire logic global_interrupt_block_command,
    input wire logic global_interrupt_unblock_command,
    input wire logic [15:0] cmd_sel,
    input wire logic [15:0] cmd_word,
    // mask control from the mask/edge setup logic
    input wire logic [NUM_EXT-1:0] ext_unmask,
    input wire logic tmr_arm,
    // interrupt sources; ext_in and power_off_in are asynchronous pins, hsc_match is used unsynchronised
    input wire logic [NUM_EXT-1:0] ext_in,
    input wire logic [NUM_HSC-1:0] hsc_match,
    input wire logic power_off_in,
    // task completion from the core
    input wire logic task_done,
    // status
    output logic instruction_error_flag,
    output logic [NUM_EXT-1:0] ext_pending,
    output logic [NUM_HSC-1:0] hsc_pending,
    output logic blocked,
    output logic [15:0] first_delay,
    // dispatch
    output logic task_start,
    output logic [3:0] task_num,
    output logic task_running,
    output logic power_off_task
);
    import pic_pkg::*;

    // ========================================
    // pin synchronisers: three stages, edge when 2nd and 3rd agree
    logic [NUM_EXT-1:0] ext_s1, ext_s2, ext_s3, ext_lvl;
    logic pof_s1, pof_s2, pof_s3, pof_lvl;
    logic [NUM_EXT-1:0] mask_prev;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ext_s1 <= '0;
            ext_s2 <= '0;
            ext_s3 <= '0;
            pof_s1 <= 1'b0;
            pof_s2 <= 1'b0;
            pof_s3 <= 1'b0;
            ext_lvl <= '0;
            pof_lvl <= 1'b0;
            mask_prev <= '0;
        end else begin
            ext_s1 <= ext_in;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            pof_s1 <= power_off_in;
            pof_s2 <= pof_s1;
            pof_s3 <= pof_s2;
            // level moves only once stages 2 and 3 agree, so a one-sample glitch never counts
            ext_lvl <= (ext_s2 & ext_s3) | (ext_lvl & (ext_s2 | ext_s3));
            pof_lvl <= (pof_s2 & pof_s3) | (pof_lvl & (pof_s2 | pof_s3));
            mask_prev <= ext_unmask;
        end
    end
    // rising edge only; edge select lives in the mask/edge setup logic
    wire [NUM_EXT-1:0] ext_rise = ext_s2 & ext_s3 & ~ext_lvl;
    wire pof_rise = pof_s2 & pof_s3 & ~pof_lvl;
    // fresh unmask wipes old records
    wire [NUM_EXT-1:0] unmask_rise = ext_unmask & ~mask_prev;

    // ========================================
    // command decode
    function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction
    wire sel_ext = in_rng(cmd_sel, SEL_EXT_LO, SEL_EXT_HI);
    wire sel_hsc = in_rng(cmd_sel, SEL_HSC_LO, SEL_HSC_HI);
    wire sel_tmr = (cmd_sel == SEL_TIMER);
    wire word_bin = (cmd_word == CW_KEEP) || (cmd_word == CW_ERASE);
    wire word_tmr = in_rng(cmd_word, TMR_MIN, TMR_MAX);
    wire sel_bad = !(sel_ext || sel_hsc || sel_tmr);
    wire word_bad = ((sel_ext || sel_hsc) && !word_bin) || (sel_tmr && !word_tmr);
    wire cmd_ok = clear_pending_command && !sel_bad && !word_bad;
    wire do_erase = cmd_ok && (cmd_word == CW_ERASE);
    wire [15:0] ext_off = cmd_sel - SEL_EXT_LO;
    wire [15:0] hsc_off = cmd_sel - SEL_HSC_LO;
    wire [NUM_EXT-1:0] ext_erase = (do_erase && sel_ext) ?
        NUM_EXT'(1) << ext_off[3:0] : '0;
    wire [NUM_HSC-1:0] hsc_erase = (do_erase && sel_hsc) ?
        NUM_HSC'(1) << hsc_off[3:0] : '0;

    // ========================================
    // error flag: updated on each command, holds between commands
    logic next_err;
    assign next_err = clear_pending_command ? (sel_bad || word_bad) : instruction_error_flag;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            instruction_error_flag <= 1'b0;
        end else begin
            instruction_error_flag <= next_err;
        end
    end

    // ========================================
    // pending records; detection wins over an erase in the same cycle
    pic_state_t state;
    wire [NUM_EXT+NUM_HSC-1:0] all_pend = {hsc_pending, ext_pending};
    logic pick_found;
    logic [3:0] pick_idx;
    wire dispatch = (state == PIC_IDLE) && pick_found && !blocked &&
        all_pend[pick_idx];
    wire [NUM_EXT+NUM_HSC-1:0] disp_clr = dispatch ?
        (NUM_EXT+NUM_HSC)'(1) << pick_idx : '0;
    wire [NUM_EXT-1:0] ext_det = ext_rise & ext_unmask;
    wire [NUM_EXT-1:0] next_ext = ((ext_pending & ~ext_erase & ~disp_clr[NUM_EXT-1:0] &
        ~unmask_rise) | ext_det);
    wire [NUM_HSC-1:0] next_hsc = ((hsc_pending & ~hsc_erase &
        ~disp_clr[NUM_EXT+NUM_HSC-1:NUM_EXT]) | hsc_match);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ext_pending <= '0;
            hsc_pending <= '0;
        end else begin
            ext_pending <= next_ext;
            hsc_pending <= next_hsc;
        end
    end

    // ========================================
    // lowest index first; inputs outrank counters
    pic_prio #(.N(NUM_EXT + NUM_HSC), .W(4)) u_prio (
        .core_clk(core_clk),
        .srst(srst),
        .req(all_pend),
        .found(pick_found),
        .idx(pick_idx)
    );

    // ========================================
    // global block / unblock; does not touch masks or timer arming
    always_ff @(posedge core_clk) begin
        if (srst) begin
            blocked <= 1'b0;
        end else if (global_interrupt_block_command) begin
            blocked <= 1'b1;
        end else if (global_interrupt_unblock_command) begin
            blocked <= 1'b0;
        end
    end

    // ========================================
    // first timer delay
    always_ff @(posedge core_clk) begin
        if (srst) begin
            first_delay <= TMR_RESET;
        end else if (cmd_ok && sel_tmr) begin
            first_delay <= cmd_word;
        end
    end

    // scheduled timer: stopped until armed, counts 0.1 ms ticks
    logic [$clog2(TICK_CYC)-1:0] tick_cnt;
    logic [15:0] tmr_cnt;
    logic tmr_fire;
    wire tick = (tick_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1));
    always_ff @(posedge core_clk) begin
        if (srst || !tmr_arm) begin
            tick_cnt <= '0;
            tmr_cnt <= TMR_RESET;
            tmr_fire <= 1'b0;
        end else begin
            tmr_fire <= 1'b0;
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
            if (tick) begin
                if (tmr_cnt + 16'h0001 >= first_delay) begin
                    tmr_cnt <= TMR_RESET;
                    tmr_fire <= !blocked;
                end else begin
                    tmr_cnt <= tmr_cnt + 16'h0001;
                end
            end
        end
    end

    // ========================================
    // dispatcher; timer task 1, inputs 2..9, counters above
    // a fired timer while busy is dropped: no pending record exists for it
    logic [3:0] next_num;
    assign next_num = pick_idx + 4'(EXT_FIRST);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= PIC_IDLE;
            task_start <= 1'b0;
            task_num <= '0;
            task_running <= 1'b0;
            power_off_task <= 1'b0;
        end else begin
            task_start <= 1'b0;
            power_off_task <= pof_rise;
            case (state)
                PIC_IDLE: begin
                    if (tmr_fire && !blocked) begin
                        state <= PIC_BUSY;
                        task_start <= 1'b1;
                        task_num <= 4'h1;
                        task_running <= 1'b1;
                    end else if (dispatch) begin
                        state <= PIC_BUSY;
                        task_start <= 1'b1;
                        task_num <= next_num;
                        task_running <= 1'b1;
                    end
                end
                PIC_BUSY: begin
                    if (task_done) begin
                        state <= PIC_IDLE;
                        task_running <= 1'b0;
                    end
                end
                default: begin
                    state <= PIC_IDLE;
                    task_running <= 1'b0;
                end
            endcase
        end
    end

    // ========================================
    // checks
    property p_err_sel;
        @(posedge core_clk) disable iff (srst)
        (clear_pending_command && sel_bad) |=> instruction_error_flag;
    endproperty
    a_err_sel: assert property (p_err_sel) else $error("bad selector not flagged");
    property p_err_word;
        @(posedge core_clk) disable iff (srst)
        (clear_pending_command && (sel_ext || sel_hsc) && cmd_word > CW_ERASE)
        |=> instruction_error_flag;
    endproperty
    a_err_word: assert property (p_err_word) else $error("bad word not flagged");
    property p_err_tmr;
        @(posedge core_clk) disable iff (srst)
        (clear_pending_command && sel_tmr && (cmd_word < TMR_MIN || cmd_word > TMR_MAX))
        |=> instruction_error_flag && $stable(first_delay);
    endproperty
    a_err_tmr: assert property (p_err_tmr) else $error("bad delay accepted");
    property p_ok;
        @(posedge core_clk) disable iff (srst)
        cmd_ok |=> !instruction_error_flag;
    endproperty
    a_ok: assert property (p_ok) else $error("error on valid command");
    property p_load;
        @(posedge core_clk) disable iff (srst)
        (cmd_ok && sel_tmr) |=> first_delay == $past(cmd_word);
    endproperty
    a_load: assert property (p_load) else $error("delay not loaded");
    property p_block;
        @(posedge core_clk) disable iff (srst)
        blocked |=> !task_start;
    endproperty
    a_block: assert property (p_block) else $error("task started while blocked");
    property p_mask;
        @(posedge core_clk) disable iff (srst)
        (ext_pending & ~$past(ext_pending) & ~$past(ext_unmask)) == '0;
    endproperty
    a_mask: assert property (p_mask) else $error("masked input recorded");
    property p_erase;
        @(posedge core_clk) disable iff (srst)
        (do_erase && sel_ext && ext_det == '0) |=> !ext_pending[$past(ext_off[2:0])];
    endproperty
    a_erase: assert property (p_erase) else $error("erase ignored");
    property p_hold;
        @(posedge core_clk) disable iff (srst)
        (task_running && !task_done) |=> !task_start;
    endproperty
    a_hold: assert property (p_hold) else $error("nested dispatch");
    c_disp: cover property (@(posedge core_clk) disable iff (srst) dispatch);
    c_tmr: cover property (@(posedge core_clk) disable iff (srst) tmr_fire);
    c_err: cover property (@(posedge core_clk) disable iff (srst) $rose(instruction_error_flag));
endmodule
`default_nettype wire

// ===== hdl/pic_pkg.sv
`default_nettype none
package pic_pkg;
    // ========================================
    // selector values and control words
    localparam logic [15:0] SEL_TIMER = 16'h0004;
    localparam logic [15:0] SEL_HSC_LO = 16'h000a;
    localparam logic [15:0] SEL_HSC_HI = 16'h000f;
    localparam logic [15:0] SEL_EXT_LO = 16'h0066;
    localparam logic [15:0] SEL_EXT_HI = 16'h006d;
    localparam logic [15:0] CW_KEEP = 16'h0000;
    localparam logic [15:0] CW_ERASE = 16'h0001;
    localparam logic [15:0] TMR_MIN = 16'h000a;
    localparam logic [15:0] TMR_MAX = 16'h270f;
    // ========================================
    // source layout and reset values
    localparam int EXT_FIRST = 2;
    localparam int NUM_EXT = 8;
    localparam int NUM_HSC = 6;
    localparam logic [15:0] TMR_RESET = 16'h0000;
    // ========================================
    // timer tick: 0.1 ms unit at 50 MHz
    localparam int CLK_HZ = 50000000;
    localparam int TICK_NS = 100000;
    localparam int TICK_CYC = TICK_NS / (1000000000 / CLK_HZ);
    // ========================================
    // dispatcher states
    typedef enum logic [1:0] {
        PIC_IDLE = 2'b00,
        PIC_BUSY = 2'b01
    } pic_state_t;
endpackage
`default_nettype wire

// ===== hdl/pic_prio.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// lowest-index picker, result registered
module pic_prio #(
    parameter int N = 8,
    parameter int W = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // request vector
    input wire logic [N-1:0] req,
    // winner
    output logic found,
    output logic [W-1:0] idx
);
    logic next_found;
    logic [W-1:0] next_idx;
    always_comb begin
        next_found = 1'b0;
        next_idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                next_found = 1'b1;
                next_idx = W'(i);
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            found <= 1'b0;
            idx <= '0;
        end else begin
            found <= next_found;
            idx <= next_idx;
        end
    end
endmodule
`default_nettype wire

// ===== tb/pic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// core side: runs each dispatched task for a set time, then ends it
module pic_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // dispatch handshake
    input wire logic task_start,
    input wire logic [7:0] hold_cyc,
    output logic task_done
);
    logic [7:0] cnt;
    logic busy;
    // a slow core lets later arrivals pile up as pending
    always_ff @(posedge core_clk) begin
        if (srst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            task_done <= 1'b0;
        end else if (task_start) begin
            busy <= 1'b1;
            cnt <= hold_cyc;
            task_done <= 1'b0;
        end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            task_done <= 1'b1;
        end else begin
            cnt <= cnt - 8'h01;
            task_done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== tb/test_pending_interrupt_clear_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_pending_interrupt_clear_ctrl;
    import pic_pkg::*;
    logic core_clk, srst, clr, blk, unblk, tmr_arm, power_off_in, task_done;
    logic [15:0] cmd_sel, cmd_word, first_delay;
    logic [7:0] ext_unmask, ext_in, ext_pending;
    logic [5:0] hsc_match, hsc_pending;
    logic instruction_error_flag, blocked, task_start, task_running, power_off_task;
    logic [3:0] task_num;
    logic [3:0] tq[$];
    int error_cnt = 0;
    int checks = 0;
    int po_cnt = 0;
    int cyc = 0;
    // selector, word, expected error
    logic [15:0] t_sel[12] = '{16'h0066, 16'h006d, 16'h0065, 16'h006e, 16'h0004, 16'h0004,
                               16'h0004, 16'h0004, 16'h000a, 16'h000f, 16'h0009, 16'h0010};
    logic [15:0] t_wrd[12] = '{16'h0001, 16'h0000, 16'h0001, 16'h0001, 16'h000a, 16'h270f,
                               16'h0009, 16'h2710, 16'h0002, 16'h0000, 16'h0001, 16'h0001};
    logic t_err[12] = '{0, 0, 1, 1, 0, 0, 1, 1, 1, 0, 1, 1};
    logic [3:0] t_ord[4] = '{4'h3, 4'h5, 4'h8, 4'ha};
    pic_ctrl DUT (.core_clk(core_clk), .srst(srst), .clear_pending_command(clr),
        .global_interrupt_block_command(blk), .global_interrupt_unblock_command(unblk),
        .cmd_sel(cmd_sel), .cmd_word(cmd_word), .ext_unmask(ext_unmask), .tmr_arm(tmr_arm),
        .ext_in(ext_in), .hsc_match(hsc_match), .power_off_in(power_off_in),
        .task_done(task_done), .instruction_error_flag(instruction_error_flag),
        .ext_pending(ext_pending), .hsc_pending(hsc_pending), .blocked(blocked),
        .first_delay(first_delay), .task_start(task_start), .task_num(task_num),
        .task_running(task_running), .power_off_task(power_off_task));
    pic_core_model core (.core_clk(core_clk), .srst(srst), .task_start(task_start),
        .hold_cyc(8'h1e), .task_done(task_done));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ========================================
    // observers and hang guard
    always @(negedge core_clk) begin
        if (task_start === 1'b1) tq.push_back(task_num);
        if (power_off_task === 1'b1) po_cnt++;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge core_clk) s = 1'b1;
        @(negedge core_clk) s = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic cmd(input logic [15:0] s, input logic [15:0] w, input logic e);
        @(negedge core_clk);
        clr = 1'b1;
        cmd_sel = s;
        cmd_word = w;
        @(negedge core_clk) clr = 1'b0;
        @(negedge core_clk);
        chk(16'(instruction_error_flag), 16'(e));
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ========================================
    // main sequence
    initial begin
        {clr, blk, unblk, tmr_arm, power_off_in} = 5'h00;
        {cmd_sel, cmd_word} = 32'h0000_0000;
        {ext_unmask, ext_in, hsc_match} = 22'h000000;
        srst = 1'b1;
        repeat (12) @(negedge core_clk);
        srst = 1'b0;
        @(negedge core_clk);
        chk({ext_pending, 2'h0, hsc_pending}, 16'h0000);
        chk(first_delay, 16'h0000);
        pulse(blk);
        chk(16'(blocked), 16'h0001);
        for (int i = 0; i < 12; i++) cmd(t_sel[i], t_wrd[i], t_err[i]);
        chk(first_delay, 16'h270f);
        // masked input records nothing; a record kept across a re-mask dies on unmask
        ext_in[6] = 1'b1;
        ext_unmask[7] = 1'b1;
        ext_in[7] = 1'b1;
        repeat (8) @(negedge core_clk);
        chk(16'(ext_pending), 16'h0080);
        ext_unmask[7] = 1'b0;
        @(negedge core_clk) ext_unmask[7] = 1'b1;
        repeat (3) @(negedge core_clk);
        chk(16'(ext_pending[7]), 16'h0000);
        ext_in = 8'h0b;
        ext_unmask = 8'hff;
        hsc_match = 6'h21;
        power_off_in = 1'b1;
        @(negedge core_clk) hsc_match = 6'h00;
        repeat (8) @(negedge core_clk);
        chk(16'(ext_pending), 16'h000b);
        chk(16'(hsc_pending), 16'h0021);
        cmd(16'h0066, 16'h0001, 1'b0);
        cmd(16'h0067, 16'h0000, 1'b0);
        chk(16'(ext_pending), 16'h000a);
        cmd(16'h000a, 16'h0000, 1'b0);
        cmd(16'h000f, 16'h0001, 1'b0);
        chk(16'(hsc_pending), 16'h0001);
        chk(16'(po_cnt), 16'h0001);
        chk(16'(tq.size()), 16'h0000);
        pulse(unblk);
        chk(16'(blocked), 16'h0000);
        for (int i = 0; i < 50 && tq.size() == 0; i++) @(negedge core_clk);
        ext_in[6] = 1'b1;
        repeat (8) @(negedge core_clk);
        chk(16'(ext_pending[6]), 16'h0001);
        chk(16'(task_running), 16'h0001);
        repeat (200) @(negedge core_clk);
        chk(16'(tq.size()), 16'h0004);
        for (int i = 0; i < 4 && i < tq.size(); i++) chk(16'(tq[i]), 16'(t_ord[i]));
        chk({ext_pending, 2'h0, hsc_pending}, 16'h0000);
        // shortest legal delay: ten ticks of 5000 cycles before task 1 starts
        cmd(16'h0004, 16'h000a, 1'b0);
        chk(first_delay, 16'h000a);
        tmr_arm = 1'b1;
        repeat (49990) @(negedge core_clk);
        chk(16'(tq.size()), 16'h0004);
        repeat (20) @(negedge core_clk);
        chk(16'(tq.size()), 16'h0005);
        chk(16'(tq[tq.size() - 1]), 16'h0001);
        stop_test();
    end
endmodule
`default_nettype wire
